/* File: core/pbd_decoder.sv */
// peripheral register block decoder: relocation, ready, mirror, lanes
`timescale 1ns/1ps
`default_nettype none

// Contract
// - block is a 256-byte aligned window
// - relocation register sits at offset a8
// - relocation resets to 00ff, top of i/o
// - relocation holds escape trap enable bit
// - peripheral bus always moves 16-bit words
// - 8-bit byte write updates whole register
// - 8-bit word relocation write acts first cycle
// - unassigned writes run but store nothing
// - block accesses mirrored onto external bus
// - external data ignored during block accesses
// - 8-bit word access takes two cycles
// - ready internal, external ready ignored
// - no waits except one for timer
// - even byte write stores whole accumulator
// - odd byte write swaps into word
// - odd word write swaps the two bytes
// - odd word read returns swapped bytes
// - byte reads fill low byte, high byte cleared to zero
module pbd_decoder
  import pbd_pkg::*;
(
  input  wire logic        ref_clk_in,      // processor clock, 20 mhz
  input  wire logic        reset_n_in,      // async reset, active low
  input  wire logic        bus8_mode_in,    // 8-bit external bus variant
  input  wire logic        core_req_in,     // access request pulse
  input  wire logic        core_mem_in,     // 1 memory, 0 i/o space
  input  wire logic        core_wr_in,      // 1 write, 0 read
  input  wire logic        core_word_in,    // 1 word, 0 byte
  input  wire logic [19:0] core_addr_in,    // byte address
  input  wire logic [15:0] core_wdata_in,   // accumulator contents
  input  wire logic        ext_ready_in,    // external ready pin
  input  wire logic [15:0] fbus_rdata_in,   // peripheral read data
  output logic             core_ready_out,  // access complete pulse
  output logic      [15:0] core_rdata_out,  // read result
  output logic             core_rd_hi_out,  // read high byte valid
  output logic             ext_cyc_out,     // external cycle active
  output logic      [19:0] ext_addr_out,    // external address
  output logic             ext_mem_out,     // external space select
  output logic             ext_wr_out,      // external write
  output logic      [15:0] ext_wdata_out,   // external write data
  output logic             fbus_wr_out,     // peripheral write strobe
  output logic             fbus_rd_out,     // peripheral read strobe
  output logic      [7:0]  fbus_addr_out,   // peripheral word offset
  output logic      [15:0] fbus_wdata_out,  // peripheral write word
  output logic             esc_trap_en_out  // trap on escape opcodes
);

  ////////////////////////////////////////////////////////////////////////////
  // state and request capture
  pbd_state_t  st_ff;          // access sequencer
  logic [19:0] addr_ff;        // current cycle address
  logic        mem_ff;         // space of request
  logic        wr_ff;          // request is a write
  logic        word_ff;        // request is a word
  logic [15:0] wdata_ff;       // accumulator latched
  logic        phase2_ff;      // second 8-bit cycle
  logic [15:0] reloc_ff;       // block base relocation
  logic        rdy_meta_ff;    // ready sync, stage one
  logic        rdy_sync_ff;    // ready sync, stage two
  logic        fbus_wr_ff;     // peripheral write strobe
  logic        fbus_rd_ff;     // peripheral read strobe
  logic [7:0]  fbus_addr_ff;   // peripheral offset
  logic [15:0] fbus_wdata_ff;  // peripheral write word
  logic        ext_cyc_ff;     // mirror cycle active
  logic [19:0] ext_addr_ff;    // mirror address
  logic        ext_mem_ff;     // mirror space
  logic        ext_wr_ff;      // mirror direction
  logic [15:0] ext_wdata_ff;   // mirror data
  logic [15:0] rdata_ff;       // read result
  logic        rd_hi_ff;       // read high valid
  logic        ready_ff;       // completion pulse

  ////////////////////////////////////////////////////////////////////////////
  // decode of the current cycle
  logic        hit_w;          // address inside block
  logic [7:0]  off_w;          // word offset in block
  logic        reloc_sel_w;    // relocation register addressed
  logic        assigned_w;     // real register addressed
  logic        timer_w;        // timer bank addressed
  logic [15:0] lane_wr_w;      // steered write word
  logic [15:0] lane_rd_w;      // steered read result
  logic        lane_hi_w;      // read fills high byte
  logic [15:0] rd_src_w;       // word being read

  // window match on space bit and twelve base bits
  assign hit_w = (mem_ff == reloc_ff[PBD_MEM_BIT])
              && (addr_ff[19:PBD_BLK_SHIFT] == reloc_ff[PBD_BASE_MSB:0]);
  assign off_w       = {addr_ff[7:1], 1'b0};
  assign reloc_sel_w = (off_w == PBD_RELOC_OFF);
  assign assigned_w  = pbd_is_assigned(off_w);
  assign timer_w     = pbd_is_timer(off_w);
  // relocation reads come from here, others from the peripheral bus
  assign rd_src_w    = fbus_rd_ff ? fbus_rdata_in : reloc_ff;

  pbd_lane_steer pbd_lane_steer_inst (
    .odd_in      (addr_ff[0]),
    .word_in     (word_ff),
    .acc_in      (wdata_ff),
    .reg_in      (rd_src_w),
    .wr_word_out (lane_wr_w),
    .rd_data_out (lane_rd_w),
    .rd_hi_out   (lane_hi_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // external ready synchroniser; only the second stage is read
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdy_meta_ff <= 1'b0;
      rdy_sync_ff <= 1'b0;
    end
    else
    begin
      rdy_meta_ff <= ext_ready_in;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer
  // one cycle to decode, optional timer wait, one cycle to finish;
  // misses wait for the synchronised external ready
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_ff     <= PBD_IDLE;
      addr_ff   <= 20'h00000;
      mem_ff    <= 1'b0;
      wr_ff     <= 1'b0;
      word_ff   <= 1'b0;
      wdata_ff  <= 16'h0000;
      phase2_ff <= 1'b0;
    end
    else
    begin
      case (st_ff)
        PBD_IDLE:
        begin
          // requests outside idle are ignored
          if (core_req_in)
          begin
            addr_ff   <= core_addr_in;
            mem_ff    <= core_mem_in;
            wr_ff     <= core_wr_in;
            word_ff   <= core_word_in;
            wdata_ff  <= core_wdata_in;
            phase2_ff <= 1'b0;
            st_ff     <= PBD_ACCESS;
          end
        end
        PBD_ACCESS:
        begin
          if (!hit_w)
            st_ff <= PBD_EXT;
          else if (timer_w)
            st_ff <= PBD_WAIT;
          else
            st_ff <= PBD_FINISH;
        end
        PBD_WAIT:
        begin
          // the single timer wait state, external ready not looked at
          st_ff <= PBD_FINISH;
        end
        PBD_EXT:
        begin
          if (rdy_sync_ff)
            st_ff <= PBD_FINISH;
        end
        PBD_FINISH:
        begin
          // word on the 8-bit bus runs a second cycle at address + 1;
          // it is re-decoded against the base, which may just have moved
          if (bus8_mode_in && word_ff && !phase2_ff)
          begin
            phase2_ff <= 1'b1;
            addr_ff   <= addr_ff + 20'h00001;
            st_ff     <= PBD_ACCESS;
          end
          else
          begin
            st_ff <= PBD_IDLE;
          end
        end
        default:
        begin
          st_ff <= PBD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // relocation register; a hit write in the first cycle moves the block
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reloc_ff <= PBD_RELOC_RST;
    end
    else if ((st_ff == PBD_ACCESS) && hit_w && wr_ff && reloc_sel_w
             && !phase2_ff)
    begin
      // whole word taken even for a byte write on the 8-bit bus
      reloc_ff <= lane_wr_w & PBD_RELOC_WMASK;
    end
  end

  // trap enable straight from the stored bit
  assign esc_trap_en_out = reloc_ff[PBD_ESC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // peripheral bus strobes: one word transfer per access, first cycle only
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      fbus_wr_ff    <= 1'b0;
      fbus_rd_ff    <= 1'b0;
      fbus_addr_ff  <= 8'h00;
      fbus_wdata_ff <= 16'h0000;
    end
    else
    begin
      fbus_wr_ff <= 1'b0;
      fbus_rd_ff <= 1'b0;
      if ((st_ff == PBD_ACCESS) && hit_w && !phase2_ff && !reloc_sel_w)
      begin
        fbus_addr_ff  <= off_w;
        fbus_wdata_ff <= lane_wr_w;
        // unassigned locations get no strobe, so nothing is kept
        fbus_wr_ff    <= wr_ff && assigned_w;
        fbus_rd_ff    <= !wr_ff && assigned_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external mirror; every cycle is shown on the pins, hit or miss
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ext_cyc_ff   <= 1'b0;
      ext_addr_ff  <= 20'h00000;
      ext_mem_ff   <= 1'b0;
      ext_wr_ff    <= 1'b0;
      ext_wdata_ff <= 16'h0000;
    end
    else if (st_ff == PBD_ACCESS)
    begin
      ext_cyc_ff  <= 1'b1;
      ext_addr_ff <= addr_ff;
      ext_mem_ff  <= mem_ff;
      ext_wr_ff   <= wr_ff;
      // second 8-bit cycle carries the high accumulator byte
      ext_wdata_ff <= phase2_ff ? {8'h00, wdata_ff[15:8]} : wdata_ff;
    end
    else if (st_ff == PBD_FINISH)
    begin
      ext_cyc_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read result and completion
  // data from the pins never enters here, so block reads stay internal
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_ff <= 16'h0000;
      rd_hi_ff <= 1'b0;
    end
    else if (fbus_rd_ff)
    begin
      rdata_ff <= lane_rd_w;
      rd_hi_ff <= lane_hi_w;
    end
    else if ((st_ff == PBD_ACCESS) && hit_w && !wr_ff && !phase2_ff
             && (reloc_sel_w || !assigned_w))
    begin
      // relocation read, or zero for an unassigned location;
      // peripheral reads leave the old result until their strobe
      rdata_ff <= reloc_sel_w ? lane_rd_w : 16'h0000;
      rd_hi_ff <= lane_hi_w;
    end
  end

  // ready pulse when the last cycle of the access finishes
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ready_ff <= 1'b0;
    else
      ready_ff <= (st_ff == PBD_FINISH)
               && !(bus8_mode_in && word_ff && !phase2_ff);
  end

  assign core_ready_out = ready_ff;
  assign core_rdata_out = rdata_ff;
  assign core_rd_hi_out = rd_hi_ff;
  assign ext_cyc_out    = ext_cyc_ff;
  assign ext_addr_out   = ext_addr_ff;
  assign ext_mem_out    = ext_mem_ff;
  assign ext_wr_out     = ext_wr_ff;
  assign ext_wdata_out  = ext_wdata_ff;
  assign fbus_wr_out    = fbus_wr_ff;
  assign fbus_rd_out    = fbus_rd_ff;
  assign fbus_addr_out  = fbus_addr_ff;
  assign fbus_wdata_out = fbus_wdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions and covers
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_block_no_wait: assert property (
    (st_ff == PBD_ACCESS) && hit_w && !timer_w |=> (st_ff == PBD_FINISH)
    ##1 core_ready_out || (st_ff == PBD_ACCESS))
    else $error("block access did not finish without wait");

  a_timer_one_wait: assert property (
    (st_ff == PBD_ACCESS) && hit_w && timer_w
    |=> (st_ff == PBD_WAIT) ##1 (st_ff == PBD_FINISH))
    else $error("timer access not exactly one wait state");

  a_miss_goes_ext: assert property (
    (st_ff == PBD_ACCESS) && (mem_ff != reloc_ff[PBD_MEM_BIT])
    |=> (st_ff == PBD_EXT))
    else $error("wrong space decoded as block hit");

  a_mirror_cycle: assert property (
    (st_ff == PBD_ACCESS) |=> ext_cyc_out && (ext_addr_out == $past(addr_ff)))
    else $error("access not mirrored on external pins");

  a_reloc_takes: assert property (
    (st_ff == PBD_ACCESS) && hit_w && wr_ff && reloc_sel_w && !phase2_ff
    |=> reloc_ff == ($past(lane_wr_w) & PBD_RELOC_WMASK))
    else $error("relocation write not taken in first cycle");

  a_unassigned_drop: assert property (
    fbus_wr_out |-> pbd_is_assigned(fbus_addr_out))
    else $error("write strobe on unassigned location");

  a_two_cycles: assert property (
    (st_ff == PBD_FINISH) && bus8_mode_in && word_ff && !phase2_ff
    |=> (st_ff == PBD_ACCESS) && phase2_ff && !core_ready_out)
    else $error("8-bit word access not split in two");

  a_odd_write_swap: assert property (
    (st_ff == PBD_ACCESS) && hit_w && wr_ff && addr_ff[0] && assigned_w
    && !reloc_sel_w && !phase2_ff
    |=> fbus_wdata_out == {$past(wdata_ff[7:0]), $past(wdata_ff[15:8])})
    else $error("odd write bytes not swapped");

  a_odd_read_swap: assert property (
    fbus_rd_out && word_ff && addr_ff[0]
    |=> core_rdata_out == {$past(fbus_rdata_in[7:0]),
                           $past(fbus_rdata_in[15:8])})
    else $error("odd word read not swapped");

  a_byte_read_low: assert property (
    fbus_rd_out && !word_ff |=> !core_rd_hi_out && (core_rdata_out[15:8] == 8'h00))
    else $error("byte read touched high byte");

  c_timer_access: cover property ((st_ff == PBD_WAIT) ##2 core_ready_out);
  c_reloc_move: cover property ((st_ff == PBD_ACCESS) && hit_w && wr_ff
    && reloc_sel_w ##[1:4] (st_ff == PBD_EXT) && phase2_ff);
  c_unassigned_wr: cover property ((st_ff == PBD_ACCESS) && hit_w && wr_ff
    && !assigned_w);
  c_miss_access: cover property ((st_ff == PBD_EXT) ##[1:8] core_ready_out);

endmodule : pbd_decoder

`default_nettype wire

/* File: core/pbd_pkg.sv */
// constants, state type and decode functions of the peripheral block decoder
package pbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // block geometry and relocation register layout
  localparam logic [7:0]  PBD_RELOC_OFF   = 8'ha8;    // relocation word offset
  localparam logic [15:0] PBD_RELOC_RST   = 16'h00ff; // top of i/o space
  localparam logic [15:0] PBD_RELOC_WMASK = 16'h5fff; // writable bits
  localparam int          PBD_BASE_MSB    = 11;       // base bits 19..8
  localparam int          PBD_MEM_BIT     = 12;       // 1 = memory space
  localparam int          PBD_ESC_BIT     = 14;       // escape trap enable
  localparam int          PBD_BLK_SHIFT   = 8;        // 256-byte window

  ////////////////////////////////////////////////////////////////////////////
  // assigned offsets inside the block
  localparam logic [7:0]  PBD_ICU_LO = 8'h02;   // interrupt unit, first
  localparam logic [7:0]  PBD_ICU_HI = 8'h1e;   // interrupt unit, last
  localparam logic [7:0]  PBD_TMR_LO = 8'h30;   // timer bank, first
  localparam logic [7:0]  PBD_TMR_HI = 8'h46;   // timer bank, last
  localparam logic [7:0]  PBD_TMR_GAP = 8'h44;  // hole in the timer bank

  // access sequencer states
  typedef enum logic [2:0] {
    PBD_IDLE,
    PBD_ACCESS,
    PBD_WAIT,
    PBD_EXT,
    PBD_FINISH
  } pbd_state_t;

  // word offset lies in the timer bank (needs one wait state)
  function automatic logic pbd_is_timer(input logic [7:0] off);
    pbd_is_timer = (off >= PBD_TMR_LO) && (off <= PBD_TMR_HI);
  endfunction : pbd_is_timer

  // word offset holds a real register
  function automatic logic pbd_is_assigned(input logic [7:0] off);
    pbd_is_assigned = ((off >= PBD_ICU_LO) && (off <= PBD_ICU_HI))
                   || (pbd_is_timer(off) && (off != PBD_TMR_GAP))
                   || (off == PBD_RELOC_OFF);
  endfunction : pbd_is_assigned

endpackage : pbd_pkg

/* File: core/pbd_lane_steer.sv */
// byte lane steering between core accumulator and 16-bit peripheral bus
`timescale 1ns/1ps
`default_nettype none

module pbd_lane_steer
  import pbd_pkg::*;
(
  input  wire logic        odd_in,       // access address is odd
  input  wire logic        word_in,      // word access
  input  wire logic [15:0] acc_in,       // accumulator write data
  input  wire logic [15:0] reg_in,       // register word being read
  output logic      [15:0] wr_word_out,  // full word stored in register
  output logic      [15:0] rd_data_out,  // result for the accumulator
  output logic             rd_hi_out     // result high byte is valid
);

  ////////////////////////////////////////////////////////////////////////////
  // writes always store a full word; odd addresses swap the halves
  always_comb
  begin
    if (odd_in)
    begin
      // low byte lands at the odd address, high byte one below
      wr_word_out = {acc_in[7:0], acc_in[15:8]};
    end
    else
    begin
      // even byte or word writes the whole accumulator
      wr_word_out = acc_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reads: odd word swaps, bytes only fill the low result byte
  always_comb
  begin
    rd_hi_out = word_in;
    if (word_in && odd_in)
    begin
      rd_data_out = {reg_in[7:0], reg_in[15:8]};
    end
    else if (word_in)
    begin
      rd_data_out = reg_in;
    end
    else if (odd_in)
    begin
      rd_data_out = {8'h00, reg_in[15:8]};
    end
    else
    begin
      rd_data_out = {8'h00, reg_in[7:0]};
    end
  end

endmodule : pbd_lane_steer

`default_nettype wire

/* File: test/pbd_fbus_model.sv */
// far-side model: peripheral registers on the word bus, external ready source
`timescale 1ns/1ps
`default_nettype none

module pbd_fbus_model
(
  input  wire logic        ref_clk_in,     // processor clock
  input  wire logic        reset_n_in,     // async reset, active low
  input  wire logic        fbus_rd_in,     // peripheral read strobe
  input  wire logic        fbus_wr_in,     // peripheral write strobe
  input  wire logic [7:0]  fbus_addr_in,   // word offset
  input  wire logic [15:0] fbus_wdata_in,  // word to store
  output logic      [15:0] fbus_rdata_out, // read word
  input  wire logic        ext_cyc_in,     // external cycle active
  input  wire logic        ready_en_in,    // external device answers
  input  wire logic [3:0]  ready_dly_in,   // cycles before ready
  output logic             ext_ready_out   // external ready pin
);
  logic [15:0] regs_ff [0:127]; // word store, zero at start
  logic [3:0]  wait_ff;         // cycles spent in the external cycle
  logic [15:0] junk_ff;         // changing value off the read strobe

  ////////////////////////////////////////////////////////////////////////////
  // store whole words only; the bus never carries bytes
  always @(posedge ref_clk_in)
  begin
    if (fbus_wr_in)
    begin
      regs_ff[fbus_addr_in[7:1]] <= fbus_wdata_in;
    end
  end

  // garbage pattern, one driver only, known start after reset
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      junk_ff <= 16'h5a5a;
    else
      junk_ff <= ~junk_ff;
  end

  // data only valid while strobed, so a late sample sees garbage
  assign fbus_rdata_out = fbus_rd_in ? regs_ff[fbus_addr_in[7:1]] : junk_ff;

  ////////////////////////////////////////////////////////////////////////////
  // slow or prompt external ready, low outside cycles
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      wait_ff <= 4'h0;
    else if (!ext_cyc_in)
      wait_ff <= 4'h0;
    else if (wait_ff != 4'hf)
      wait_ff <= wait_ff + 4'h1;
  end
  assign ext_ready_out = ready_en_in && ext_cyc_in && (wait_ff >= ready_dly_in);

  initial
  begin
    for (int i = 0; i < 128; i++) regs_ff[i] = 16'h0000;
  end
endmodule : pbd_fbus_model
`default_nettype wire

/* File: test/tb_pbd_decoder.sv */
// self-checking bench of the peripheral block decoder
`timescale 1ns/1ps
`default_nettype none

module tb_pbd_decoder;
  import pbd_pkg::*;

  `define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    fail_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, bus8_mode_in = 1'b0;
  logic core_req_in = 1'b0, core_mem_in = 1'b0, core_wr_in = 1'b0;
  logic core_word_in = 1'b0, ready_en = 1'b0;
  logic [3:0]  ready_dly = 4'h0;
  logic [19:0] core_addr_in = 20'h00000;
  logic [15:0] core_wdata_in = 16'h0000;
  logic ext_ready_in, core_ready_out, core_rd_hi_out, ext_cyc_out;
  logic ext_mem_out, ext_wr_out, fbus_wr_out, fbus_rd_out, esc_trap_en_out;
  logic [15:0] fbus_rdata_in, core_rdata_out, ext_wdata_out, fbus_wdata_out;
  logic [19:0] ext_addr_out;
  logic [7:0]  fbus_addr_out;
  int fail_count = 0, comparisons = 0, cyc = 0;
  // results of the last access
  int lat, ncyc, fwr_n;
  logic [15:0] rdv, fwd, ewd;
  logic [19:0] ea;
  logic [7:0]  fwa;
  logic rdh, ewr, emem;

  typedef struct {logic w; logic wd; logic [19:0] a; logic [15:0] d;
                  int lat; logic [15:0] ex; logic st;} pbd_row_t;
  // i/o block at 0ff00; ex is read result or stored word
  pbd_row_t rows [18] = '{
    '{1,1,20'h0ff02,16'h1234,3,16'h1234,1}, '{0,1,20'h0ff02,0,3,16'h1234,0},
    '{0,1,20'h0ff03,0,3,16'h3412,0}, '{0,0,20'h0ff03,0,3,16'h0012,0},
    '{0,0,20'h0ff02,0,3,16'h0034,0}, '{1,0,20'h0ff0b,16'habcd,3,16'hcdab,1},
    '{0,1,20'h0ff0a,0,3,16'hcdab,0}, '{1,0,20'h0ff08,16'h5a6b,3,16'h5a6b,1},
    '{0,1,20'h0ff08,0,3,16'h5a6b,0}, '{1,1,20'h0ff0d,16'h1122,3,16'h2211,1},
    '{0,1,20'h0ff0c,0,3,16'h2211,0}, '{1,1,20'h0ff30,16'h7777,4,16'h7777,1},
    '{0,1,20'h0ff30,0,4,16'h7777,0}, '{1,1,20'h0ff20,16'hbeef,3,16'hbeef,0},
    '{0,1,20'h0ff20,0,3,16'h0000,0}, '{1,1,20'h0ff44,16'hbeef,4,16'hbeef,0},
    '{0,1,20'h0ff44,0,4,16'h0000,0}, '{0,1,20'h0ffa8,0,3,16'h00ff,0}};

  always #25 ref_clk_in = ~ref_clk_in;

  pbd_decoder pbd_decoder_inst (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .bus8_mode_in(bus8_mode_in),
    .core_req_in(core_req_in), .core_mem_in(core_mem_in),
    .core_wr_in(core_wr_in), .core_word_in(core_word_in),
    .core_addr_in(core_addr_in), .core_wdata_in(core_wdata_in),
    .ext_ready_in(ext_ready_in), .fbus_rdata_in(fbus_rdata_in),
    .core_ready_out(core_ready_out), .core_rdata_out(core_rdata_out),
    .core_rd_hi_out(core_rd_hi_out), .ext_cyc_out(ext_cyc_out),
    .ext_addr_out(ext_addr_out), .ext_mem_out(ext_mem_out),
    .ext_wr_out(ext_wr_out), .ext_wdata_out(ext_wdata_out),
    .fbus_wr_out(fbus_wr_out), .fbus_rd_out(fbus_rd_out),
    .fbus_addr_out(fbus_addr_out), .fbus_wdata_out(fbus_wdata_out),
    .esc_trap_en_out(esc_trap_en_out));

  pbd_fbus_model pbd_fbus_model_inst (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .fbus_rd_in(fbus_rd_out),
    .fbus_wr_in(fbus_wr_out), .fbus_addr_in(fbus_addr_out),
    .fbus_wdata_in(fbus_wdata_out), .fbus_rdata_out(fbus_rdata_in),
    .ext_cyc_in(ext_cyc_out), .ready_en_in(ready_en),
    .ready_dly_in(ready_dly), .ext_ready_out(ext_ready_in));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, shared by the watchdog
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // whole run is a few dozen accesses at most
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  // one core access; request held for a single edge, results sampled settled
  task automatic do_acc(input logic m, input logic w, input logic wd,
                        input logic [19:0] a, input logic [15:0] d);
    logic pc;
    logic done;
    pc = 1'b0;
    done = 1'b0;
    @(posedge ref_clk_in);
    core_req_in <= 1'b1;
    core_mem_in <= m;
    core_wr_in <= w;
    core_word_in <= wd;
    core_addr_in <= a;
    core_wdata_in <= d;
    lat = 0;
    ncyc = 0;
    fwr_n = 0;
    while (!done && lat < 80)
    begin
      @(posedge ref_clk_in);
      core_req_in <= 1'b0;
      lat++;
      #1;
      if (ext_cyc_out === 1'b1 && !pc)
      begin
        ncyc++;
        if (ncyc == 1)
        begin
          ea = ext_addr_out; ewr = ext_wr_out; emem = ext_mem_out;
          ewd = ext_wdata_out;
        end
      end
      pc = (ext_cyc_out === 1'b1);
      if (fbus_wr_out === 1'b1)
      begin
        fwr_n++; fwa = fbus_addr_out; fwd = fbus_wdata_out;
      end
      if (core_ready_out === 1'b1)
      begin
        done = 1'b1; rdv = core_rdata_out; rdh = core_rd_hi_out;
      end
    end
    `CHK("completed", 1'b1, done)
  endtask : do_acc

  task automatic do_reset(input logic b8);
    @(posedge ref_clk_in);
    reset_n_in <= 1'b0;
    bus8_mode_in <= b8;
    repeat (4) @(posedge ref_clk_in);
    // released on the edge; outputs still show reset values just after it
    reset_n_in <= 1'b1;
    #1;
    `CHK("rst_ready", 1'b0, core_ready_out)
    `CHK("rst_cyc", 1'b0, ext_cyc_out)
    `CHK("rst_esc", 1'b0, esc_trap_en_out)
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    do_reset(1'b0);
    // table rows, external ready never given, so hits must answer alone
    foreach (rows[i])
    begin
      do_acc(1'b0, rows[i].w, rows[i].wd, rows[i].a, rows[i].d);
      `CHK("latency", rows[i].lat, lat)
      `CHK("mirror_n", 1, ncyc)
      `CHK("mirror_a", rows[i].a, ea)
      `CHK("mirror_w", rows[i].w, ewr)
      if (rows[i].w)
      begin
        `CHK("mirror_d", rows[i].d, ewd)
        `CHK("stored_n", int'(rows[i].st), fwr_n)
        if (rows[i].st)
        begin
          `CHK("store_w", rows[i].ex, fwd)
          `CHK("store_a", {rows[i].a[7:1], 1'b0}, fwa)
        end
      end
      else
      begin
        `CHK("read_d", rows[i].ex, rdv)
        `CHK("read_hi", rows[i].wd, rdh)
      end
    end
    // outside the block: only external ready ends it
    ready_en <= 1'b1;
    ready_dly <= 4'h3;
    do_acc(1'b0, 1'b0, 1'b1, 20'h0fe00, 16'h0000);
    `CHK("miss_wait", 1'b1, lat > 5)
    // move to memory 10000 with escape trap set
    do_acc(1'b0, 1'b1, 1'b1, 20'h0ffa8, 16'h5100);
    `CHK("esc_on", 1'b1, esc_trap_en_out)
    do_acc(1'b1, 1'b0, 1'b1, 20'h100a8, 16'h0000);
    `CHK("reloc_rd", 16'h5100, rdv)
    do_acc(1'b1, 1'b0, 1'b1, 20'h10002, 16'h0000);
    `CHK("moved_rd", 16'h1234, rdv)
    `CHK("moved_lat", 3, lat)
    `CHK("moved_mem", 1'b1, emem)
    do_acc(1'b0, 1'b0, 1'b1, 20'h0ff02, 16'h0000);
    `CHK("old_miss", 1'b1, lat > 5)
    do_acc(1'b1, 1'b1, 1'b1, 20'h100a8, 16'hffff);
    do_acc(1'b1, 1'b0, 1'b1, 20'hfffa8, 16'h0000);
    `CHK("reloc_mask", 16'h5fff, rdv)
    // 8-bit variant after a second reset
    ready_en <= 1'b0;
    do_reset(1'b1);
    do_acc(1'b0, 1'b0, 1'b1, 20'h0ffa8, 16'h0000);
    `CHK("b8_reset", 16'h00ff, rdv)
    `CHK("b8_rd_n", 2, ncyc)
    do_acc(1'b0, 1'b1, 1'b1, 20'h0ff04, 16'h1357);
    `CHK("b8_wr_n", 2, ncyc)
    `CHK("b8_wr_st", 1, fwr_n)
    `CHK("b8_wr_d", 16'h1357, fwd)
    do_acc(1'b0, 1'b1, 1'b0, 20'h0ff06, 16'h2468);
    `CHK("b8_byte_n", 1, ncyc)
    `CHK("b8_byte_d", 16'h2468, fwd)
    do_acc(1'b0, 1'b0, 1'b1, 20'h0ff06, 16'h0000);
    `CHK("b8_byte_rd", 16'h2468, rdv)
    // word move: second half lands outside and waits for the pin
    ready_en <= 1'b1;
    ready_dly <= 4'h6;
    do_acc(1'b0, 1'b1, 1'b1, 20'h0ffa8, 16'h1100);
    `CHK("b8_mv_n", 2, ncyc)
    `CHK("b8_mv_wait", 1'b1, lat > 10)
    ready_en <= 1'b0;
    do_acc(1'b1, 1'b0, 1'b1, 20'h100a8, 16'h0000);
    `CHK("b8_mv_rd", 16'h1100, rdv)
    `CHK("b8_mv_lat", 1'b1, lat < 12)
    // byte write moves the block back in one cycle, as software should
    do_acc(1'b1, 1'b1, 1'b0, 20'h100a8, 16'h00ff);
    `CHK("b8_rb_n", 1, ncyc)
    // reserved location written with zero keeps nothing
    do_acc(1'b0, 1'b1, 1'b1, 20'h0ff22, 16'h0000);
    `CHK("b8_rsv_st", 0, fwr_n)
    do_acc(1'b0, 1'b0, 1'b1, 20'h0ffa8, 16'h0000);
    `CHK("b8_rb_rd", 16'h00ff, rdv)
    summarize();
  end
endmodule : tb_pbd_decoder
`default_nettype wire
